// ===== core/cfo_pkg.sv
package cfo_pkg;

  // ****************************************
  // Option codes and payload lengths
  // ****************************************
  localparam int PAY_MAX = 20;
  localparam logic [7:0] OPT_SM = 8'h04;
  localparam logic [7:0] OPT_CAP = 8'h05;
  localparam logic [7:0] OPT_APP = 8'h06;
  localparam logic [7:0] OPT_FILE = 8'h08;
  localparam logic [4:0] LEN_SM = 5'h02;
  localparam logic [4:0] LEN_CAP = 5'h0a;
  localparam logic [4:0] LEN_APP_S = 5'h11;
  localparam logic [4:0] LEN_APP_L = 5'h13;
  localparam logic [4:0] LEN_FILE = 5'h03;
  localparam logic [4:0] LEN_FID = 5'h02;
  localparam logic [4:0] LEN_PAIR = 5'h02;
  localparam logic [4:0] NAME_MIN = 5'h01;
  localparam logic [4:0] NAME_LIM = 5'h10;
  localparam logic [4:0] CNT_MAX = 5'h14;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SM_CHAIN_BIT = 2;
  localparam int CAP1_POS = 4;
  localparam int CAP5_POS = 8;
  localparam int CAP6_POS = 9;
  localparam int LR_MODE_BIT = 1;
  localparam int NAME_POS = 1;
  localparam int NAME_MAX = 16;
  localparam int FID_FLAG_BIT = 7;
  localparam int TWO_BIT = 1;
  localparam int UPD_BIT = 0;
  localparam int OLD1_POS = 1;
  localparam int NEW1_POS = 2;
  localparam int OLD2_POS_F = 5;
  localparam int OLD2_POS_N = 3;
  localparam int FID_POS [3] = '{17, 3, 7};
  localparam logic [15:0] FID_RSV [4] = '{16'h0000, 16'h3f00, 16'h3fff, 16'hffff};

  // ****************************************
  // Status words
  // ****************************************
  localparam logic [15:0] SW_NONE = 16'h0000;
  localparam logic [15:0] SW_OK = 16'h9100;
  localparam logic [15:0] SW_LEN = 16'h917e;
  localparam logic [15:0] SW_PARAM = 16'h919e;
  localparam logic [15:0] SW_DENIED = 16'h919d;

  // ****************************************
  // APB register map
  // ****************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DATA = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_CFG = 8'h0c;
  localparam logic [7:0] A_CAP = 8'h10;
  localparam logic [7:0] A_FID = 8'h14;
  localparam logic [7:0] A_REN0 = 8'h18;
  localparam logic [7:0] A_REN1 = 8'h1c;
  localparam int GO_BIT = 8;
  localparam int CLR_BIT = 9;

  typedef enum logic [0:0] {
    CFO_IDLE = 1'b0,
    CFO_EXEC = 1'b1
  } cfo_fsm_t;

  typedef struct packed {
    logic chain_block;
    logic lr_mode;
    logic [7:0] cap1;
    logic [7:0] cap5;
    logic [7:0] cap6;
    logic app_renamed;
    logic [4:0] name_len;
    logic [15:0][7:0] dir_name;
    logic [15:0] app_fid;
    logic files_renamed;
    logic [1:0] ren_valid;
    logic [1:0] ren_fid_upd;
    logic [1:0][7:0] ren_old;
    logic [1:0][7:0] ren_new;
    logic [1:0][15:0] ren_fid;
  } cfo_cfg_t;

  typedef struct packed {
    cfo_fsm_t fsm;
    logic [7:0] opt;
    logic [PAY_MAX-1:0][7:0] pay;
    logic [4:0] cnt;
    logic [15:0] sw;
    logic [31:0] rdata;
    cfo_cfg_t cfg;
  } cfo_st_t;

endpackage

// ===== core/cfo_fid_chk.sv
`timescale 1ns/1ns
module cfo_fid_chk
  import cfo_pkg::*;
(
  // Payload bytes
  input wire logic [7:0] lsb,
  input wire logic [7:0] msb,
  // Result
  output logic [15:0] fid,
  output logic rsv
);

  // ****************************************
  // Identifier assembly
  // ****************************************
  always_comb begin
    fid = {msb, lsb};
    rsv = 1'b0;
    for (int i = 0; i < $size(FID_RSV); i++) begin
      if (fid == FID_RSV[i]) begin
        rsv = 1'b1;
      end
    end
  end

endmodule // cfo_fid_chk

// ===== core/cfo_parser.sv
`timescale 1ns/1ns
module cfo_parser
  import cfo_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Stored configuration
  output cfo_cfg_t cfg
);

  cfo_st_t st_ff;
  cfo_st_t nxt_st;
  logic [2:0][15:0] fid_v;
  logic [2:0] fid_rsv;
  logic acc;
  logic wr;

  function automatic logic reg_known(input logic [7:0] a);
    return a == A_CTRL || a == A_DATA || a == A_STAT || a == A_CFG ||
           a == A_CAP || a == A_FID || a == A_REN0 || a == A_REN1;
  endfunction

  // ****************************************
  // Identifier checkers
  // ****************************************
  for (genvar k = 0; k < 3; k++) begin : g_fid
    cfo_fid_chk u_chk (
      .lsb(st_ff.pay[FID_POS[k]]),
      .msb(st_ff.pay[FID_POS[k]+1]),
      .fid(fid_v[k]),
      .rsv(fid_rsv[k])
    );
  end

  // ****************************************
  // Bus answer
  // ****************************************
  // Every access completes in its first access cycle
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign pready = 1'b1;
  assign prdata = st_ff.rdata;
  assign cfg = st_ff.cfg;

  // Writes while a command runs are refused so the payload stays stable
  always_comb begin
    pslverr = 1'b0;
    if (acc) begin
      if (!reg_known(paddr)) begin
        pslverr = 1'b1;
      end else if (pwrite && st_ff.fsm == CFO_EXEC) begin
        pslverr = 1'b1;
      end else if (pwrite && paddr == A_DATA && st_ff.cnt == CNT_MAX) begin
        pslverr = 1'b1;
      end
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic ok;
    logic len_bad;
    logic once_bad;
    logic two;
    logic upd;
    logic pad_ok;
    logic [4:0] nl;
    logic [4:0] exp_len;
    int o2;
    ok = 1'b0;
    len_bad = 1'b0;
    once_bad = 1'b0;
    two = 1'b0;
    upd = 1'b0;
    pad_ok = 1'b1;
    nl = 5'h00;
    exp_len = 5'h00;
    o2 = OLD2_POS_N;
    nxt_st = st_ff;

    // Read data is caught in the setup cycle
    if (psel && !penable) begin
      unique case (paddr)
        A_STAT: nxt_st.rdata = {3'h0, st_ff.cnt, 7'h00, st_ff.fsm, st_ff.sw};
        A_CFG: nxt_st.rdata = {16'h0000, 3'h0, st_ff.cfg.name_len, 3'h0,
                               st_ff.cfg.files_renamed, st_ff.cfg.app_renamed,
                               1'b0, st_ff.cfg.lr_mode, st_ff.cfg.chain_block};
        A_CAP: nxt_st.rdata = {8'h00, st_ff.cfg.cap6, st_ff.cfg.cap5, st_ff.cfg.cap1};
        A_FID: nxt_st.rdata = {16'h0000, st_ff.cfg.app_fid};
        A_REN0: nxt_st.rdata = {st_ff.cfg.ren_fid[0], st_ff.cfg.ren_new[0],
                                st_ff.cfg.ren_old[0]};
        A_REN1: nxt_st.rdata = {st_ff.cfg.ren_fid[1], st_ff.cfg.ren_new[1],
                                st_ff.cfg.ren_old[1]};
        A_CTRL: nxt_st.rdata = {24'h000000, st_ff.opt};
        default: nxt_st.rdata = 32'h00000000;
      endcase
    end

    unique case (st_ff.fsm)
      CFO_IDLE: begin
        if (wr && paddr == A_CTRL) begin
          nxt_st.opt = pwdata[7:0];
          if (pwdata[CLR_BIT]) begin
            nxt_st.cnt = 5'h00;
          end
          if (pwdata[GO_BIT]) begin
            nxt_st.fsm = CFO_EXEC;
          end
        end
        if (wr && paddr == A_DATA && st_ff.cnt != CNT_MAX) begin
          nxt_st.pay[st_ff.cnt] = pwdata[7:0];
          nxt_st.cnt = st_ff.cnt + 5'h01;
        end
      end
      CFO_EXEC: begin
        nxt_st.fsm = CFO_IDLE;
        nxt_st.cnt = 5'h00;
        case (st_ff.opt)
          OPT_SM: begin
            len_bad = st_ff.cnt != LEN_SM;
            if (!len_bad) begin
              ok = 1'b1;
              // Other bits of the field are reserved and dropped
              if (st_ff.pay[0][SM_CHAIN_BIT]) begin
                nxt_st.cfg.chain_block = 1'b1;
              end
            end
          end
          OPT_CAP: begin
            len_bad = st_ff.cnt != LEN_CAP;
            if (!len_bad) begin
              ok = 1'b1;
              // Only the mode bit of byte one is kept
              nxt_st.cfg.cap1[LR_MODE_BIT] = st_ff.cfg.cap1[LR_MODE_BIT] |
                st_ff.pay[CAP1_POS][LR_MODE_BIT];
              nxt_st.cfg.cap5 = st_ff.pay[CAP5_POS];
              nxt_st.cfg.cap6 = st_ff.pay[CAP6_POS];
              if (st_ff.pay[CAP1_POS][LR_MODE_BIT]) begin
                nxt_st.cfg.lr_mode = 1'b1;
              end
            end
          end
          OPT_APP: begin
            once_bad = st_ff.cfg.app_renamed;
            len_bad = st_ff.cnt != LEN_APP_S && st_ff.cnt != LEN_APP_L;
            nl = st_ff.pay[0][4:0];
            for (int i = 0; i < NAME_MAX; i++) begin
              if (5'(i) >= nl && st_ff.pay[NAME_POS+i] != 8'h00) begin
                pad_ok = 1'b0;
              end
            end
            // The long form carries an identifier and must say so
            if (!once_bad && !len_bad && nl >= NAME_MIN && nl <= NAME_LIM &&
                pad_ok && (st_ff.cnt == LEN_APP_S ||
                (st_ff.pay[0][FID_FLAG_BIT] && !fid_rsv[0]))) begin
              ok = 1'b1;
              nxt_st.cfg.app_renamed = 1'b1;
              nxt_st.cfg.name_len = nl;
              for (int i = 0; i < NAME_MAX; i++) begin
                nxt_st.cfg.dir_name[i] = st_ff.pay[NAME_POS+i];
              end
              if (st_ff.cnt == LEN_APP_L) begin
                nxt_st.cfg.app_fid = fid_v[0];
              end
            end
          end
          OPT_FILE: begin
            once_bad = st_ff.cfg.files_renamed;
            two = st_ff.pay[0][TWO_BIT];
            upd = st_ff.pay[0][UPD_BIT];
            exp_len = LEN_FILE + (upd ? LEN_FID : 5'h00);
            if (two) begin
              exp_len = exp_len + LEN_PAIR + (upd ? LEN_FID : 5'h00);
            end
            o2 = upd ? OLD2_POS_F : OLD2_POS_N;
            len_bad = st_ff.cnt != exp_len;
            if (!once_bad && !len_bad && !(upd && fid_rsv[1]) &&
                !(upd && two && fid_rsv[2])) begin
              ok = 1'b1;
              nxt_st.cfg.files_renamed = 1'b1;
              nxt_st.cfg.ren_valid = {two, 1'b1};
              nxt_st.cfg.ren_fid_upd = {two && upd, upd};
              nxt_st.cfg.ren_old[0] = st_ff.pay[OLD1_POS];
              nxt_st.cfg.ren_new[0] = st_ff.pay[NEW1_POS];
              if (upd) begin
                nxt_st.cfg.ren_fid[0] = fid_v[1];
              end
              if (two) begin
                nxt_st.cfg.ren_old[1] = st_ff.pay[o2];
                nxt_st.cfg.ren_new[1] = st_ff.pay[o2+1];
                if (upd) begin
                  nxt_st.cfg.ren_fid[1] = fid_v[2];
                end
              end
            end
          end
          default: begin
            once_bad = 1'b1;
          end
        endcase
        // Leakage-resilient mode can only ever be set
        nxt_st.cfg.lr_mode = nxt_st.cfg.lr_mode | st_ff.cfg.lr_mode;
        if (ok) begin
          nxt_st.sw = SW_OK;
        end else begin
          nxt_st.cfg = st_ff.cfg;
          nxt_st.sw = once_bad ? SW_DENIED : (len_bad ? SW_LEN : SW_PARAM);
        end
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_chain_set: assert property (@(posedge clock) disable iff (sys_rst)
    st_ff.fsm == CFO_EXEC && st_ff.opt == OPT_SM && st_ff.cnt == LEN_SM &&
    st_ff.pay[0][SM_CHAIN_BIT] |=> cfg.chain_block && st_ff.sw == SW_OK)
    else $error("chain block not set");

  a_cap_bytes: assert property (@(posedge clock) disable iff (sys_rst)
    st_ff.fsm == CFO_EXEC && st_ff.opt == OPT_CAP && st_ff.cnt == LEN_CAP
    |=> cfg.cap5 == $past(st_ff.pay[CAP5_POS]) && cfg.cap6 == $past(st_ff.pay[CAP6_POS]))
    else $error("capability bytes misplaced");

  a_mode_enable: assert property (@(posedge clock) disable iff (sys_rst)
    st_ff.fsm == CFO_EXEC && st_ff.opt == OPT_CAP && st_ff.cnt == LEN_CAP &&
    st_ff.pay[CAP1_POS][LR_MODE_BIT] |=> cfg.lr_mode)
    else $error("mode not enabled");

  a_mode_keep: assert property (@(posedge clock) disable iff (sys_rst)
    st_ff.fsm == CFO_EXEC && st_ff.opt == OPT_CAP && !st_ff.pay[CAP1_POS][LR_MODE_BIT]
    |=> cfg.lr_mode == $past(cfg.lr_mode))
    else $error("mode changed by clear bit");

  a_mode_sticky: assert property (@(posedge clock) disable iff (sys_rst)
    cfg.lr_mode |=> cfg.lr_mode [*2])
    else $error("mode was cleared");

  a_app_once: assert property (@(posedge clock) disable iff (sys_rst)
    st_ff.fsm == CFO_EXEC && st_ff.opt == OPT_APP &&
    (cfg.app_renamed || (st_ff.cnt != LEN_APP_S && st_ff.cnt != LEN_APP_L))
    |=> st_ff.sw != SW_OK && $stable(cfg))
    else $error("renaming accepted wrongly");

  a_name_range: assert property (@(posedge clock) disable iff (sys_rst)
    st_ff.fsm == CFO_EXEC && st_ff.opt == OPT_APP &&
    (st_ff.pay[0][4:0] < NAME_MIN || st_ff.pay[0][4:0] > NAME_LIM)
    |=> st_ff.sw != SW_OK)
    else $error("bad name length accepted");

  a_fid_order: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(cfg.app_renamed) && $past(st_ff.cnt) == LEN_APP_L
    |-> cfg.app_fid == {st_ff.pay[FID_POS[0]+1], st_ff.pay[FID_POS[0]]})
    else $error("identifier byte order");

  a_fid_rsv: assert property (@(posedge clock) disable iff (sys_rst)
    st_ff.fsm == CFO_EXEC && st_ff.opt == OPT_APP && st_ff.cnt == LEN_APP_L &&
    fid_rsv[0] |=> !$rose(cfg.app_renamed))
    else $error("reserved identifier accepted");

  a_file_len: assert property (@(posedge clock) disable iff (sys_rst)
    st_ff.fsm == CFO_EXEC && st_ff.opt == OPT_FILE && st_ff.cnt != LEN_FILE &&
    st_ff.cnt != 5'h05 && st_ff.cnt != 5'h09 |=> st_ff.sw == SW_LEN || st_ff.sw == SW_DENIED)
    else $error("file length accepted");

  a_exec_done: assert property (@(posedge clock) disable iff (sys_rst)
    st_ff.fsm == CFO_EXEC |=> st_ff.fsm == CFO_IDLE && st_ff.sw != SW_NONE)
    else $error("command did not finish");

  a_chain_keep: assert property (@(posedge clock) disable iff (sys_rst)
    st_ff.fsm == CFO_EXEC && st_ff.opt == OPT_SM && !st_ff.pay[0][SM_CHAIN_BIT]
    |=> cfg.chain_block == $past(cfg.chain_block))
    else $error("chain block changed by clear bit");

  a_sm_len: assert property (@(posedge clock) disable iff (sys_rst)
    st_ff.fsm == CFO_EXEC && st_ff.opt == OPT_SM && st_ff.cnt != LEN_SM
    |=> st_ff.sw == SW_LEN && $stable(cfg))
    else $error("bad messaging length accepted");

  a_cap_rsv: assert property (@(posedge clock) disable iff (sys_rst)
    (cfg.cap1 & ~(8'h01 << LR_MODE_BIT)) == 8'h00)
    else $error("reserved capability bit stored");

  a_app_short: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(cfg.app_renamed) && $past(st_ff.cnt) == LEN_APP_S
    |-> cfg.app_fid == $past(cfg.app_fid))
    else $error("short form changed identifier");

  a_file_once: assert property (@(posedge clock) disable iff (sys_rst)
    st_ff.fsm == CFO_EXEC && st_ff.opt == OPT_FILE && cfg.files_renamed
    |=> st_ff.sw == SW_DENIED && $stable(cfg))
    else $error("second file renaming accepted");

  a_ren_upd: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(cfg.files_renamed) |-> cfg.ren_fid_upd[0] == $past(st_ff.pay[0][UPD_BIT]) &&
    (cfg.ren_fid_upd[0] || cfg.ren_fid == $past(cfg.ren_fid)))
    else $error("identifier update flag wrong");

  a_ren_first: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(cfg.files_renamed) |-> cfg.ren_old[0] == st_ff.pay[OLD1_POS] &&
    cfg.ren_new[0] == st_ff.pay[NEW1_POS])
    else $error("first file numbers misplaced");

  a_ren_count: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(cfg.files_renamed) |-> cfg.ren_valid == {$past(st_ff.pay[0][TWO_BIT]), 1'b1})
    else $error("renamed file count wrong");

endmodule // cfo_parser

// ===== verif/cfo_reader.sv
`timescale 1ns/1ns
// ****************************************
// Reader model on the APB side
// ****************************************
module cfo_reader (
  // Clock
  input wire logic clock,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // Released write data is inverted so a stale value can never pass as fresh
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait for the slave
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule // cfo_reader

// ===== verif/config_option_parser_tb_top.sv
`timescale 1ns/1ns
module config_option_parser_tb_top;
  import cfo_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [15:0] fid;
  logic [7:0] pl [PAY_MAX];
  cfo_cfg_t cfg;
  int fails, tests_run, seed, k, i;

  cfo_parser dut_u (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg(cfg));
  cfo_reader rdr_u (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] fid_of(input logic [7:0] lo, input logic [7:0] hi);
    return {hi, lo};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Clear, load payload, start, then poll until busy drops
  task automatic cmd(input logic [7:0] opt, input int n, input logic [15:0] sw);
    int j;
    rdr_u.xfer(1'b1, A_CTRL, 32'h200, rv, err);
    for (j = 0; j < n; j++) begin
      rdr_u.xfer(1'b1, A_DATA, {24'h0, pl[j]}, rv, err);
    end
    rdr_u.xfer(1'b1, A_CTRL, {23'h0, 1'b1, opt}, rv, err);
    chk("go err", 32'h0, {31'h0, err});
    j = 0;
    do begin
      rdr_u.xfer(1'b0, A_STAT, 32'h0, rv, err);
      j++;
    end while (rv[16] !== 1'b0 && j < 20);
    chk("busy", 32'h0, {31'h0, rv[16]});
    chk("status", {16'h0, sw}, {16'h0, rv[15:0]});
  endtask

  task automatic app(input logic [4:0] len, input int n, input logic [15:0] f,
                     input logic bad, input logic [15:0] sw);
    int j;
    pl[0] = {1'b1, 2'($random(seed)), len};
    for (j = 1; j <= 16; j++) begin
      pl[j] = (j <= len) ? (8'($random(seed)) | 8'h01) : 8'h00;
    end
    if (bad) begin
      pl[16] = 8'h5a;
    end
    pl[17] = f[7:0];
    pl[18] = f[15:8];
    cmd(OPT_APP, n, sw);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    fails++;
    stop_test();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    seed = 32'h01b7;
    fails = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk("cfg reset", 32'h1, {31'h0, cfg === '0});
    pl[0] = 8'($random(seed)) & 8'hfb;
    pl[1] = 8'($random(seed));
    cmd(OPT_SM, 2, SW_OK);
    chk("chain clear", 32'h0, {31'h0, cfg.chain_block});
    pl[0] = pl[0] | 8'h04;
    cmd(OPT_SM, 3, SW_LEN);
    chk("chain bad len", 32'h0, {31'h0, cfg.chain_block});
    cmd(OPT_SM, 2, SW_OK);
    chk("chain set", 32'h1, {31'h0, cfg.chain_block});
    for (k = 0; k < 3; k++) begin
      for (i = 0; i < 10; i++) begin
        pl[i] = 8'($random(seed));
      end
      pl[4][1] = (k == 1);
      cmd(OPT_CAP, 10, SW_OK);
      chk("mode", {31'h0, k != 0}, {31'h0, cfg.lr_mode});
      chk("cap5", {24'h0, pl[8]}, {24'h0, cfg.cap5});
      chk("cap6", {24'h0, pl[9]}, {24'h0, cfg.cap6});
    end
    chk("cap1", {24'h0, 8'h01 << LR_MODE_BIT}, {24'h0, cfg.cap1});
    for (k = 0; k < 4; k++) begin
      app(5'h05, 19, FID_RSV[k], 1'b0, SW_PARAM);
    end
    app(5'h00, 19, 16'h1234, 1'b0, SW_PARAM);
    app(5'h11, 19, 16'h1234, 1'b0, SW_PARAM);
    app(5'h05, 19, 16'h1234, 1'b1, SW_PARAM);
    app(5'h05, 18, 16'h1234, 1'b0, SW_LEN);
    chk("not renamed", 32'h0, {31'h0, cfg.app_renamed});
    fid = {8'h12, 8'($random(seed))};
    app(5'h10, 19, fid, 1'b0, SW_OK);
    chk("app fid", {16'h0, fid_of(pl[17], pl[18])}, {16'h0, cfg.app_fid});
    chk("name len", 32'h10, {27'h0, cfg.name_len});
    for (i = 0; i < 16; i++) begin
      chk("name byte", {24'h0, pl[i + 1]}, {24'h0, cfg.dir_name[i]});
    end
    app(5'h05, 19, 16'h4321, 1'b0, SW_DENIED);
    chk("app fid kept", {16'h0, fid}, {16'h0, cfg.app_fid});
    for (i = 1; i < 9; i++) begin
      // Low byte kept off 00h and ffh so no identifier is a reserved one
      pl[i] = (8'($random(seed)) | 8'h01) & 8'h7f;
    end
    pl[0] = {6'($random(seed)), 2'b11};
    cmd(OPT_FILE, 4, SW_LEN);
    cmd(OPT_FILE, 9, SW_OK);
    chk("old1", {24'h0, pl[1]}, {24'h0, cfg.ren_old[0]});
    chk("new1", {24'h0, pl[2]}, {24'h0, cfg.ren_new[0]});
    chk("fid1", {16'h0, fid_of(pl[3], pl[4])}, {16'h0, cfg.ren_fid[0]});
    chk("old2", {24'h0, pl[5]}, {24'h0, cfg.ren_old[1]});
    chk("new2", {24'h0, pl[6]}, {24'h0, cfg.ren_new[1]});
    chk("fid2", {16'h0, fid_of(pl[7], pl[8])}, {16'h0, cfg.ren_fid[1]});
    chk("ren flags", 32'hf, {28'h0, cfg.ren_valid, cfg.ren_fid_upd});
    cmd(OPT_FILE, 9, SW_DENIED);
    rdr_u.xfer(1'b1, 8'h20, 32'h0, rv, err);
    chk("unmapped", 32'h1, {31'h0, err});
    // Second reset mid-run makes the one-time options available again
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk("cfg re-reset", 32'h1, {31'h0, cfg === '0});
    app(5'h03, 17, 16'h0000, 1'b0, SW_OK);
    chk("short fid", 32'h0, {16'h0, cfg.app_fid});
    rdr_u.xfer(1'b0, A_CFG, 32'h0, rv, err);
    chk("cfg reg", 32'h00000308, rv);
    pl[0] = {6'($random(seed)), 2'b00};
    pl[1] = 8'($random(seed));
    pl[2] = 8'($random(seed));
    cmd(OPT_FILE, 3, SW_OK);
    chk("ren flags one", 32'h4, {28'h0, cfg.ren_valid, cfg.ren_fid_upd});
    chk("fid1 kept", 32'h0, {16'h0, cfg.ren_fid[0]});
    rdr_u.xfer(1'b0, A_REN0, 32'h0, rv, err);
    chk("ren0 reg", {16'h0, pl[2], pl[1]}, rv);
    rdr_u.xfer(1'b1, A_CTRL, 32'h200, rv, err);
    for (i = 0; i <= PAY_MAX; i++) begin
      rdr_u.xfer(1'b1, A_DATA, {24'h0, 8'($random(seed))}, rv, err);
    end
    chk("overflow", 32'h1, {31'h0, err});
    rdr_u.xfer(1'b0, A_STAT, 32'h0, rv, err);
    chk("count", PAY_MAX, {27'h0, rv[28:24]});
    stop_test();
  end
endmodule // config_option_parser_tb_top
